// File: core/acc_pkg.sv
`default_nettype none
package acc_pkg;

  // Register byte addresses on the APB side
  localparam logic [11:0] OFF_CTRL0 = 12'h000;
  localparam logic [11:0] OFF_CTRL1 = 12'h004;
  localparam logic [11:0] OFF_RESH  = 12'h008;
  localparam logic [11:0] OFF_RESL  = 12'h00c;
  localparam logic [11:0] OFF_FLAG  = 12'h010;

  // Reset values
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] RES_RST   = 8'h00;

  // Field positions inside the flag register
  localparam int FLAG_DONE_BIT = 0;

  // Channel select codes
  localparam logic [4:0] CH_LAST_EXT = 5'h10;
  localparam logic [4:0] CH_TEMP     = 5'h1d;
  localparam logic [4:0] CH_DAC      = 5'h1e;
  localparam logic [4:0] CH_FVR      = 5'h1f;

  // Positive reference codes
  localparam logic [1:0] PREF_VDD = 2'h0;
  localparam logic [1:0] PREF_EXT = 2'h2;
  localparam logic [1:0] PREF_FVR = 2'h3;

  // Conversion clock codes; low two bits 11 pick the RC oscillator
  localparam logic [2:0] CLK_DIV2  = 3'h0;
  localparam logic [2:0] CLK_DIV4  = 3'h4;
  localparam logic [2:0] CLK_DIV8  = 3'h1;
  localparam logic [2:0] CLK_DIV16 = 3'h5;
  localparam logic [2:0] CLK_DIV32 = 3'h2;
  localparam logic [2:0] CLK_DIV64 = 3'h6;
  localparam logic [1:0] CLK_RC    = 2'h3;

  // Timing: one conversion is 11.5 bit times, counted in half bit times
  localparam int         RESULT_BITS      = 10;
  localparam logic [3:0] RESULT_MSB       = 4'h9;
  localparam logic [4:0] CONV_HALF_TICKS  = 5'h17;
  localparam logic [4:0] FIRST_BIT_TICK   = 5'h01;
  localparam logic [4:0] LAST_BIT_TICK    = 5'h14;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01
  } acc_state_t;

  typedef struct packed {
    logic       unused7;
    logic [4:0] channel_select;
    logic       conversion_status;
    logic       converter_enable;
  } acc_ctrl0_t;

  typedef struct packed {
    logic       result_format;
    logic [2:0] conversion_clock_select;
    logic       unused3;
    logic       negative_reference_select;
    logic [1:0] positive_reference_select;
  } acc_ctrl1_t;

  typedef struct packed {
    logic       converter_power;
    logic       sample_track;
    logic [9:0] sar_trial;
    logic [4:0] ext_channel;
    logic       ext_connect;
    logic       temp_connect;
    logic       dac_connect;
    logic       fvr_connect;
    logic       nref_external;
    logic       pref_vdd;
    logic       pref_ext;
    logic       pref_fvr;
  } acc_analog_t;

  // Half bit time, in pclk cycles minus one, for each divided clock
  function automatic logic [5:0] acc_half_limit(input logic [2:0] sel);
    case (sel)
      CLK_DIV2:  acc_half_limit = 6'h00;
      CLK_DIV4:  acc_half_limit = 6'h01;
      CLK_DIV8:  acc_half_limit = 6'h03;
      CLK_DIV16: acc_half_limit = 6'h07;
      CLK_DIV32: acc_half_limit = 6'h0f;
      CLK_DIV64: acc_half_limit = 6'h1f;
      default:   acc_half_limit = 6'h00;
    endcase
  endfunction : acc_half_limit

endpackage : acc_pkg
`default_nettype wire

// File: core/acc_top.sv
`timescale 1ns/1ps
`default_nettype none
module acc_top (
  input  wire logic                pclk,            // System clock
  input  wire logic                presetn,         // Asynchronous reset, active low
  input  wire logic                psel,            // APB select
  input  wire logic                penable,         // APB access phase
  input  wire logic                pwrite,          // APB direction
  input  wire logic [11:0]         paddr,           // APB byte address
  input  wire logic [31:0]         pwdata,          // APB write data
  input  wire logic [3:0]          pstrb,           // APB byte strobes
  output logic      [31:0]         prdata,          // APB read data
  output logic                     pready,          // APB ready
  output logic                     pslverr,         // APB error, unmapped address
  input  wire logic                cmp5_trigger,    // Special event pulse, pclk domain
  input  wire logic                comparator_in,   // Analog comparator, asynchronous
  input  wire logic                rc_osc_in,       // Dedicated RC oscillator, asynchronous
  output logic                     timer_one_reset, // One-cycle pulse to timer one
  output acc_pkg::acc_analog_t     analog_ctl       // Analog switch and DAC controls
);
  import acc_pkg::*;

  logic [1:0]  cmp_sync_ff;
  logic [2:0]  rc_sync_ff;
  logic        comp_s;
  logic        rc_edge;

  acc_state_t  state_ff, nxt_state;
  acc_ctrl0_t  ctrl0_ff, nxt_ctrl0;
  acc_ctrl1_t  ctrl1_ff, nxt_ctrl1;
  logic [7:0]  resh_ff, nxt_resh;
  logic [7:0]  resl_ff, nxt_resl;
  logic        flag_ff, nxt_flag;
  logic [5:0]  div_ff, nxt_div;
  logic [4:0]  hcnt_ff, nxt_hcnt;
  logic [3:0]  ndone_ff, nxt_ndone;
  logic [9:0]  sar_ff, nxt_sar;
  logic        last_ff, nxt_last;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        pready_ff, nxt_pready;
  logic        pslverr_ff, nxt_pslverr;
  logic        tmr_ff, nxt_tmr;
  acc_analog_t ana_ff, nxt_ana;

  logic        half_tick;
  logic [3:0]  bidx;
  logic        fill;
  logic [9:0]  part;
  acc_ctrl0_t  wr0;
  logic        acc_cyc, wr_cyc, hit, start, stop, kill, done, load;
  logic [7:0]  rd_byte;

  // Two-flop synchronisers; the extra RC stage feeds only the edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_sync_ff <= 2'h0;
      rc_sync_ff  <= 3'h0;
    end else begin
      cmp_sync_ff <= {cmp_sync_ff[0], comparator_in};
      rc_sync_ff  <= {rc_sync_ff[1:0], rc_osc_in};
    end
  end

  assign comp_s  = cmp_sync_ff[1];
  // Both RC edges count, so each edge is half a bit time
  assign rc_edge = rc_sync_ff[2] ^ rc_sync_ff[1];
  assign bidx    = RESULT_MSB - ndone_ff;
  // Nothing decided yet means there is no last bit to copy
  assign fill    = (ndone_ff != 4'h0) ? last_ff : 1'b0;

  // Partial result: every undecided bit copies the last decided one
  genvar gi;
  for (gi = 0; gi < RESULT_BITS; gi++) begin : g_part
    assign part[gi] = ((gi + int'(ndone_ff)) < RESULT_BITS) ? fill : sar_ff[gi];
  end

  // Next-state logic for bus, registers and converter sequencing
  always_comb begin
    nxt_state   = state_ff;
    nxt_ctrl0   = ctrl0_ff;
    nxt_ctrl1   = ctrl1_ff;
    nxt_resh    = resh_ff;
    nxt_resl    = resl_ff;
    nxt_flag    = flag_ff;
    nxt_div     = div_ff;
    nxt_hcnt    = hcnt_ff;
    nxt_ndone   = ndone_ff;
    nxt_sar     = sar_ff;
    nxt_last    = last_ff;
    nxt_prdata  = prdata_ff;
    nxt_pslverr = pslverr_ff;
    nxt_tmr     = cmp5_trigger;
    start       = 1'b0;
    stop        = 1'b0;
    kill        = 1'b0;
    done        = 1'b0;
    load        = 1'b0;
    half_tick   = 1'b0;
    wr0         = acc_ctrl0_t'(pwdata[7:0]);

    // Read decode; the status bit reflects the sequencer directly
    hit = 1'b1;
    case (paddr)
      OFF_CTRL0: rd_byte = {1'b0, ctrl0_ff.channel_select, state_ff == ST_CONV, ctrl0_ff.converter_enable};
      OFF_CTRL1: rd_byte = ctrl1_ff;
      OFF_RESH:  rd_byte = resh_ff;
      OFF_RESL:  rd_byte = resl_ff;
      OFF_FLAG:  rd_byte = {7'h00, flag_ff};
      default: begin
        rd_byte = 8'h00;
        hit     = 1'b0;
      end
    endcase

    // One wait state keeps prdata and pready straight from flops
    nxt_pready = psel & penable & ~pready_ff;
    if (psel && penable && !pready_ff) begin
      nxt_prdata  = {24'h000000, rd_byte};
      nxt_pslverr = ~hit;
    end
    acc_cyc = psel & penable & pready_ff;
    wr_cyc  = acc_cyc & pwrite & pstrb[0] & hit;

    if (wr_cyc) begin
      case (paddr)
        OFF_CTRL0: begin
          nxt_ctrl0.channel_select   = wr0.channel_select;
          nxt_ctrl0.converter_enable = wr0.converter_enable;
          // Enable must already be on; setting both in one write is refused
          if (wr0.conversion_status && wr0.converter_enable && ctrl0_ff.converter_enable) begin
            start = 1'b1;
          end
          if (!wr0.conversion_status) begin
            stop = 1'b1;
          end
          if (!wr0.converter_enable) begin
            kill = 1'b1;
          end
        end
        OFF_CTRL1: begin
          nxt_ctrl1         = acc_ctrl1_t'(pwdata[7:0]);
          nxt_ctrl1.unused3 = 1'b0;
        end
        OFF_RESH: nxt_resh = pwdata[7:0];
        OFF_RESL: nxt_resl = pwdata[7:0];
        OFF_FLAG: begin
          if (pwdata[FLAG_DONE_BIT]) begin
            nxt_flag = 1'b0;
          end
        end
        default: nxt_flag = flag_ff;
      endcase
    end

    // Hardware trigger needs the enable; it never checks acquisition time
    if (cmp5_trigger && ctrl0_ff.converter_enable) begin
      start = 1'b1;
    end

    // Half bit-time ticks from the divider or the RC oscillator edges
    if (ctrl1_ff.conversion_clock_select[1:0] == CLK_RC) begin
      half_tick = rc_edge;
    end else if (div_ff >= acc_half_limit(ctrl1_ff.conversion_clock_select)) begin
      half_tick = 1'b1;
    end

    case (state_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_state = ST_CONV;
          nxt_div   = 6'h00;
          nxt_hcnt  = 5'h00;
          nxt_ndone = 4'h0;
          nxt_sar   = 10'h000;
          nxt_last  = 1'b0;
        end
      end
      ST_CONV: begin
        nxt_div = half_tick ? 6'h00 : div_ff + 6'h01;
        if (half_tick) begin
          nxt_hcnt = hcnt_ff + 5'h01;
          // Odd half tick offers a trial bit, even one keeps the decision
          if (hcnt_ff >= FIRST_BIT_TICK && hcnt_ff <= LAST_BIT_TICK) begin
            if (hcnt_ff[0]) begin
              nxt_sar[bidx] = 1'b1;
            end else begin
              nxt_sar[bidx] = comp_s;
              nxt_last      = comp_s;
              nxt_ndone     = ndone_ff + 4'h1;
            end
          end
          if (hcnt_ff == CONV_HALF_TICKS - 5'h01) begin
            done = 1'b1;
          end
        end
        // Disabling drops the conversion without touching the result
        if (kill) begin
          nxt_state = ST_IDLE;
        end else if (stop || done) begin
          nxt_state = ST_IDLE;
          load      = 1'b1;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase

    // Result load wins over a software write in the same cycle
    if (load) begin
      if (ctrl1_ff.result_format) begin
        nxt_resh = {6'h00, part[9:8]};
        nxt_resl = part[7:0];
      end else begin
        nxt_resh = part[9:2];
        nxt_resl = {part[1:0], 6'h00};
      end
    end
    // Placed after the clear so a set in the same cycle wins
    if (done && !kill) begin
      nxt_flag = 1'b1;
    end

    // Analog controls follow the next register state
    nxt_ana.converter_power = nxt_ctrl0.converter_enable;
    nxt_ana.sample_track    = nxt_ctrl0.converter_enable & (nxt_state == ST_IDLE);
    nxt_ana.sar_trial       = nxt_sar;
    nxt_ana.ext_connect     = nxt_ctrl0.channel_select <= CH_LAST_EXT;
    nxt_ana.ext_channel     = nxt_ana.ext_connect ? nxt_ctrl0.channel_select : 5'h00;
    nxt_ana.temp_connect    = nxt_ctrl0.channel_select == CH_TEMP;
    nxt_ana.dac_connect     = nxt_ctrl0.channel_select == CH_DAC;
    nxt_ana.fvr_connect     = nxt_ctrl0.channel_select == CH_FVR;
    nxt_ana.nref_external   = nxt_ctrl1.negative_reference_select;
    nxt_ana.pref_vdd        = nxt_ctrl1.positive_reference_select == PREF_VDD;
    nxt_ana.pref_ext        = nxt_ctrl1.positive_reference_select == PREF_EXT;
    nxt_ana.pref_fvr        = nxt_ctrl1.positive_reference_select == PREF_FVR;
  end

  // State registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff   <= ST_IDLE;
      ctrl0_ff   <= acc_ctrl0_t'(CTRL0_RST);
      ctrl1_ff   <= acc_ctrl1_t'(CTRL1_RST);
      resh_ff    <= RES_RST;
      resl_ff    <= RES_RST;
      flag_ff    <= 1'b0;
      div_ff     <= 6'h00;
      hcnt_ff    <= 5'h00;
      ndone_ff   <= 4'h0;
      sar_ff     <= 10'h000;
      last_ff    <= 1'b0;
      prdata_ff  <= 32'h00000000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      tmr_ff     <= 1'b0;
      ana_ff     <= '0;
    end else begin
      state_ff   <= nxt_state;
      ctrl0_ff   <= nxt_ctrl0;
      ctrl1_ff   <= nxt_ctrl1;
      resh_ff    <= nxt_resh;
      resl_ff    <= nxt_resl;
      flag_ff    <= nxt_flag;
      div_ff     <= nxt_div;
      hcnt_ff    <= nxt_hcnt;
      ndone_ff   <= nxt_ndone;
      sar_ff     <= nxt_sar;
      last_ff    <= nxt_last;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      tmr_ff     <= nxt_tmr;
      ana_ff     <= nxt_ana;
    end
  end

  assign prdata          = prdata_ff;
  assign pready          = pready_ff;
  assign pslverr         = pslverr_ff;
  assign timer_one_reset = tmr_ff;
  assign analog_ctl      = ana_ff;

endmodule : acc_top
`default_nettype wire

// File: tb/acc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module acc_checker import acc_pkg::*; (
  input wire logic                 pclk,            // Clock
  input wire logic                 presetn,         // Reset
  input wire logic                 psel,            // Select
  input wire logic                 penable,         // Access
  input wire logic                 pwrite,          // Direction
  input wire logic [11:0]          paddr,           // Address
  input wire logic [31:0]          pwdata,          // Write data
  input wire logic [3:0]           pstrb,           // Strobes
  input wire logic [31:0]          prdata,          // Read data
  input wire logic                 pready,          // Ready
  input wire logic                 pslverr,         // Error
  input wire logic                 cmp5_trigger,    // Trigger
  input wire logic                 comparator_in,   // Comparator
  input wire logic                 rc_osc_in,       // RC clock
  input wire logic                 timer_one_reset, // Timer clear
  input wire acc_pkg::acc_analog_t analog_ctl       // Analog controls
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Committed write; the switches change at the commit edge, checked two edges later
  logic wc;
  assign wc = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
  a_trig_clears_timer:
    assert property (cmp5_trigger |=> timer_one_reset) else $error("timer clear missing");
  a_no_stray_clear:
    assert property (!cmp5_trigger |=> !timer_one_reset) else $error("stray timer clear");
  a_power_on_enable:
    assert property (wc && paddr == OFF_CTRL0 |-> ##2 analog_ctl.converter_power == $past(pwdata[0], 2))
    else $error("power wrong");
  a_ext_route:
    assert property (wc && paddr == OFF_CTRL0 && pwdata[6:2] <= CH_LAST_EXT |-> ##2 analog_ctl.ext_connect
      && analog_ctl.ext_channel == $past(pwdata[6:2], 2)) else $error("external route wrong");
  a_reserved_open:
    assert property (wc && paddr == OFF_CTRL0 && pwdata[6:2] > CH_LAST_EXT && pwdata[6:2] < CH_TEMP |-> ##2
      !(analog_ctl.ext_connect || analog_ctl.temp_connect || analog_ctl.dac_connect || analog_ctl.fvr_connect))
    else $error("reserved code connects");
  a_inner_source:
    assert property (wc && paddr == OFF_CTRL0 && pwdata[6:2] >= CH_TEMP |-> ##2 !analog_ctl.ext_connect
      && {analog_ctl.temp_connect, analog_ctl.dac_connect, analog_ctl.fvr_connect} == {$past(pwdata[6:2], 2)
      == CH_TEMP, $past(pwdata[6:2], 2) == CH_DAC, $past(pwdata[6:2], 2) == CH_FVR}) else $error("inner source");
  a_ref_select:
    assert property (wc && paddr == OFF_CTRL1 |-> ##2 analog_ctl.nref_external == $past(pwdata[2], 2)
      && {analog_ctl.pref_vdd, analog_ctl.pref_ext, analog_ctl.pref_fvr} == {$past(pwdata[1:0], 2) == 2'h0,
      $past(pwdata[1:0], 2) == 2'h2, $past(pwdata[1:0], 2) == 2'h3}) else $error("reference wrong");
  a_unimpl_zero:
    assert property (pready && !pwrite |-> !(paddr == OFF_CTRL0 && prdata[7]) && !(paddr == OFF_CTRL1
      && prdata[3])) else $error("unimplemented bit set");
  c_start: cover property (wc && paddr == OFF_CTRL0 && pwdata[1:0] == 2'h3);
  c_trig: cover property (timer_one_reset);
  c_err: cover property (pready && pslverr);
endmodule : acc_checker
bind acc_top acc_checker u_acc_checker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cmp5_trigger(cmp5_trigger), .comparator_in(comparator_in), .rc_osc_in(rc_osc_in),
  .timer_one_reset(timer_one_reset), .analog_ctl(analog_ctl));
`default_nettype wire

// File: tb/acc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model (
  input  wire acc_pkg::acc_analog_t analog_ctl,    // Switch controls
  input  wire logic [9:0]           level,         // Input level in codes
  output logic                      comparator_in, // Level at or above trial
  output logic                      rc_osc_in      // Free RC clock
);
  import acc_pkg::*;
  logic wander = 1'b0; // Unpowered comparator output is not trustworthy
  // Oscillator edges land on pclk edges, rising on rising and falling on falling, so the synchroniser sees only two phases
  initial begin
    rc_osc_in = 1'b0;
    forever #55 rc_osc_in = ~rc_osc_in;
  end
  always #7 wander = ~wander;
  assign comparator_in = analog_ctl.converter_power ? (level >= analog_ctl.sar_trial) : wander;
endmodule : acc_analog_model
`default_nettype wire

// File: tb/test_acc_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_acc_top;
  import acc_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cmp5_trigger = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, comparator_in, rc_osc_in, timer_one_reset, e;
  logic [9:0]  level = 10'h000;
  logic [7:0]  q;
  acc_analog_t analog_ctl;
  int          n_mismatch = 0, check_count = 0, cyc = 0;
  acc_top u_acc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp5_trigger(cmp5_trigger), .comparator_in(comparator_in), .rc_osc_in(rc_osc_in),
    .timer_one_reset(timer_one_reset), .analog_ctl(analog_ctl));
  acc_analog_model u_acc_analog_model (.analog_ctl(analog_ctl), .level(level), .comparator_in(comparator_in),
    .rc_osc_in(rc_osc_in));
  initial begin
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One transfer, held until pready is seen high at an edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      n_mismatch++;
      wrap_up();
    end
  endtask : bus
  // Poll until the busy bit drops; a stuck converter ends the run
  task automatic wait_idle;
    for (int n = 0; n < 400; n++) begin
      bus(1'b0, OFF_CTRL0, 8'h00);
      if (q[1] === 1'b0) return;
    end
    n_mismatch++;
    wrap_up();
  endtask : wait_idle
  task automatic t_regs;
    logic [11:0] a[5];
    a = '{OFF_CTRL0, OFF_CTRL1, OFF_RESH, OFF_RESL, OFF_FLAG};
    foreach (a[i]) begin
      bus(1'b0, a[i], 8'h00);
      chk(q, 8'h00);
    end
    bus(1'b1, OFF_CTRL0, 8'hff);
    bus(1'b0, OFF_CTRL0, 8'h00);
    chk(q, 8'h7d);
    bus(1'b1, OFF_CTRL1, 8'hff);
    bus(1'b0, OFF_CTRL1, 8'h00);
    chk(q, 8'hf7);
    bus(1'b1, OFF_RESH, 8'h5a);
    bus(1'b0, OFF_RESH, 8'h00);
    chk(q, 8'h5a);
    bus(1'b1, 12'h014, 8'hff);
    bus(1'b0, 12'h014, 8'h00);
    chk({e, q}, 9'h100);
  endtask : t_regs
  // Every channel code and reference setting; the checker judges the switches
  task automatic t_sweep;
    for (int i = 0; i < 32; i++) begin
      bus(1'b1, OFF_CTRL0, {1'b0, i[4:0], 2'b00});
      bus(1'b0, OFF_CTRL0, 8'h00);
      chk(q, {1'b0, i[4:0], 2'b00});
    end
    for (int i = 0; i < 8; i++) bus(1'b1, OFF_CTRL1, {5'h00, i[2:0]});
  endtask : t_sweep
  // Full conversion; h is the half bit time in pclk cycles, 0 for the RC clock
  task automatic conv(input logic fmt, input logic [2:0] cs, input logic [9:0] t, input int h);
    int c0;
    level = t;
    bus(1'b1, OFF_CTRL1, {fmt, cs, 4'h0});
    bus(1'b1, OFF_CTRL0, 8'h01);
    bus(1'b1, OFF_CTRL0, 8'h03);
    c0 = cyc;
    wait_idle();
    if (h > 0) chk(cyc - c0 >= 23 * h && cyc - c0 <= 23 * h + 8, 1);
    bus(1'b0, OFF_FLAG, 8'h00);
    chk(q, 8'h01);
    // The two fastest clocks decide on a stale comparator, so only timing and the flag are judged
    if (h == 0 || h >= 4) begin
      bus(1'b0, OFF_RESH, 8'h00);
      chk(q, fmt ? {6'h00, t[9:8]} : t[9:2]);
      bus(1'b0, OFF_RESL, 8'h00);
      chk(q, fmt ? t[7:0] : {t[1:0], 6'h00});
    end
    bus(1'b1, OFF_FLAG, 8'h01);
    bus(1'b0, OFF_FLAG, 8'h00);
    chk(q, 8'h00);
  endtask : conv
  // Abort after two decided bits: every undecided bit copies the last one
  // Run once with a last bit of one and once of zero, so no constant fill passes
  task automatic t_abort(input logic [9:0] lv, input logic [7:0] eh, input logic [7:0] el);
    level = lv;
    bus(1'b1, OFF_CTRL1, {1'b1, CLK_DIV64, 4'h0});
    bus(1'b1, OFF_CTRL0, 8'h03);
    repeat (200) @(posedge pclk);
    bus(1'b1, OFF_CTRL0, 8'h01);
    bus(1'b0, OFF_CTRL0, 8'h00);
    chk(q, 8'h01);
    bus(1'b0, OFF_FLAG, 8'h00);
    chk(q, 8'h00);
    bus(1'b0, OFF_RESH, 8'h00);
    chk(q, eh);
    bus(1'b0, OFF_RESL, 8'h00);
    chk(q, el);
  endtask : t_abort
  task automatic pulse;
    @(posedge pclk);
    cmp5_trigger <= 1'b1;
    @(posedge pclk);
    cmp5_trigger <= 1'b0;
  endtask : pulse
  task automatic t_trig;
    bus(1'b1, OFF_CTRL0, 8'h00);
    pulse();
    bus(1'b0, OFF_CTRL0, 8'h00);
    chk(q, 8'h00);
    bus(1'b1, OFF_CTRL0, 8'h01);
    pulse();
    bus(1'b0, OFF_CTRL0, 8'h00);
    chk(q, 8'h03);
    chk(analog_ctl.sample_track, 1'b0);
    wait_idle();
    chk(analog_ctl.sample_track, 1'b1);
    bus(1'b0, OFF_FLAG, 8'h00);
    chk(q, 8'h01);
    bus(1'b0, OFF_RESH, 8'h00);
    chk(q, {6'h00, level[9:8]});
    // Disabling mid-conversion drops it: no flag, results kept
    bus(1'b1, OFF_FLAG, 8'h01);
    pulse();
    bus(1'b1, OFF_CTRL0, 8'h00);
    bus(1'b0, OFF_CTRL0, 8'h00);
    chk(q, 8'h00);
    bus(1'b0, OFF_FLAG, 8'h00);
    chk(q, 8'h00);
    bus(1'b0, OFF_RESH, 8'h00);
    chk(q, {6'h00, level[9:8]});
  endtask : t_trig
  // A second reset in mid-run returns the control registers to zero
  task automatic t_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, OFF_CTRL1, 8'h00);
    chk(q, 8'h00);
    bus(1'b0, OFF_CTRL0, 8'h00);
    chk(q, 8'h00);
  endtask : t_reset
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_sweep();
    conv(1'b1, CLK_DIV2, 10'h155, 1);
    conv(1'b0, CLK_DIV4, 10'h2aa, 2);
    conv(1'b1, CLK_DIV8, 10'h2a5, 4);
    conv(1'b0, CLK_DIV16, 10'h15a, 8);
    conv(1'b1, CLK_DIV32, 10'h3c3, 16);
    conv(1'b0, CLK_DIV64, 10'h001, 32);
    conv(1'b1, {1'b0, CLK_RC}, 10'h0ff, 0);
    conv(1'b0, {1'b1, CLK_RC}, 10'h200, 0);
    t_abort(10'h3ff, 8'h03, 8'hff);
    t_abort(10'h200, 8'h02, 8'h00);
    t_trig();
    t_reset();
    wrap_up();
  end
endmodule : test_acc_top
`default_nettype wire
